// [foc_supervisory_control.sv]
// supervisory run control, field weakening and bus ripple compensation
`timescale 1ns/1ps
`include "foc_supervisory_map.svh"
module foc_supervisory_control #(
	parameter bit TORQUE_ONLY_SELECT = 1'b0
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [11:0]                s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output      logic                       s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output      logic                       s_axi_wready,
	output      logic [1:0]                 s_axi_bresp,
	output      logic                       s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [11:0]                s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output      logic                       s_axi_arready,
	output      logic [31:0]                s_axi_rdata,
	output      logic [1:0]                 s_axi_rresp,
	output      logic                       s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       start_stop_button,
	input  wire logic                       fault_in,
	output      logic                       conversion_start,
	input  wire logic                       conversion_done,
	input  wire foc_supervisory_pkg::q15_t  pot_reference,
	input  wire foc_supervisory_pkg::q15_t  measured_speed,
	input  wire foc_supervisory_pkg::q15_t  speed_pi_output,
	input  wire foc_supervisory_pkg::q15_t  d_pi_output,
	input  wire foc_supervisory_pkg::q15_t  q_pi_output,
	input  wire foc_supervisory_pkg::q15_t  estimator_angle,
	input  wire foc_supervisory_pkg::q15_t  bus_voltage_measured,
	output      logic                       windings_enable,
	output      logic                       regulators_run,
	output      logic                       speed_pi_enable,
	output      logic                       control_clear,
	output      foc_supervisory_pkg::q15_t  speed_error,
	output      foc_supervisory_pkg::q15_t  velocity_reference,
	output      foc_supervisory_pkg::q15_t  q_current_reference,
	output      foc_supervisory_pkg::q15_t  d_current_reference,
	output      foc_supervisory_pkg::q15_t  commutation_angle,
	output      foc_supervisory_pkg::q15_t  direct_voltage_command,
	output      foc_supervisory_pkg::q15_t  quadrature_voltage_command,
	output      logic                       commands_valid
);
	import foc_supervisory_pkg::*;

	// ====================================================================
	// register bus
	logic        ripple_en_q;
	logic [15:0] rated_speed_rpm;
	logic [15:0] max_weakened_speed_rpm;
	logic signed [15:0] bus_voltage_target;
	logic [15:0] ramp_accel_q;
	logic [15:0] ramp_steps_q;
	logic [15:0] pwm_period_q;
	q15_t        weak_table_q [16];
	logic        aw_held_q;
	logic        w_held_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic        wstrb_any_q;
	logic        do_write;
	logic        wr_hit;
	run_state_t  state_q;

	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_hit        = (awaddr_q <= `REG_RAMP_STEPS + 12'h004)
		|| (awaddr_q >= `REG_TABLE_BASE && awaddr_q <= `REG_TABLE_TOP);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q    <= 1'b0;
			w_held_q     <= 1'b0;
			awaddr_q     <= '0;
			wdata_q      <= '0;
			wstrb_any_q  <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q    <= 1'b1;
				wdata_q     <= s_axi_wdata;
				// strobes only mean something while wvalid stands, so keep them with the data
				wstrb_any_q <= (s_axi_wstrb != 4'h0);
			end
			if (do_write)
			begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// byte strobes are ignored below the word: every field is written whole
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ripple_en_q            <= 1'b0;
			rated_speed_rpm        <= `RATED_RESET;
			max_weakened_speed_rpm <= `MAXW_RESET;
			bus_voltage_target     <= `TARGET_RESET;
			ramp_accel_q           <= `ACCEL_RESET;
			ramp_steps_q           <= `STEPS_RESET;
			pwm_period_q           <= `PERIOD_RESET;
		end
		else if (do_write && wstrb_any_q)
		begin
			unique case (awaddr_q)
				`REG_CTRL:       ripple_en_q <= wdata_q[`CTRL_RIPPLE_BIT];
				`REG_RATED:      rated_speed_rpm <= wdata_q[15:0];
				`REG_MAXW:       max_weakened_speed_rpm <= wdata_q[15:0];
				`REG_BUS_TARGET: bus_voltage_target <= wdata_q[15:0];
				`REG_RAMP_ACCEL: ramp_accel_q <= wdata_q[15:0];
				`REG_RAMP_STEPS: ramp_steps_q <= wdata_q[15:0];
				`REG_PWM_PERIOD: pwm_period_q <= wdata_q[15:0];
				default: ;
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_table
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					weak_table_q[gi] <= '0;
				else if (do_write && wstrb_any_q
					&& awaddr_q == `REG_TABLE_BASE + 12'(gi * 4))
					weak_table_q[gi] <= wdata_q[15:0];
			end
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `RESP_OKAY;
			if (s_axi_araddr >= `REG_TABLE_BASE && s_axi_araddr <= `REG_TABLE_TOP)
				s_axi_rdata <= {{16{weak_table_q[s_axi_araddr[5:2]][15]}},
					weak_table_q[s_axi_araddr[5:2]]};
			else
			begin
				unique case (s_axi_araddr)
					`REG_CTRL:       s_axi_rdata <= {31'h0, ripple_en_q};
					`REG_STATUS:     s_axi_rdata <= {26'h0, TORQUE_ONLY_SELECT, state_q};
					`REG_RATED:      s_axi_rdata <= {16'h0, rated_speed_rpm};
					`REG_MAXW:       s_axi_rdata <= {16'h0, max_weakened_speed_rpm};
					`REG_BUS_TARGET: s_axi_rdata <= {16'h0, bus_voltage_target};
					`REG_RAMP_ACCEL: s_axi_rdata <= {16'h0, ramp_accel_q};
					`REG_RAMP_STEPS: s_axi_rdata <= {16'h0, ramp_steps_q};
					`REG_PWM_PERIOD: s_axi_rdata <= {16'h0, pwm_period_q};
					default:
					begin
						s_axi_rdata <= '0;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
	assign s_axi_arready = !s_axi_rvalid;

	// ====================================================================
	// pins: button and fault pass three flops, then a fourth that follows only two agreeing samples
	logic [2:0] btn_sync_q;
	logic [2:0] flt_sync_q;
	logic       btn_q;
	logic       btn_prev_q;
	logic       flt_q;
	logic       btn_press;
	logic       fault;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			btn_sync_q <= '0;
			flt_sync_q <= '0;
			btn_q      <= 1'b0;
			btn_prev_q <= 1'b0;
			flt_q      <= 1'b0;
		end
		else
		begin
			btn_sync_q <= {btn_sync_q[1:0], start_stop_button};
			flt_sync_q <= {flt_sync_q[1:0], fault_in};
			if (btn_sync_q[1] == btn_sync_q[2])
				btn_q <= btn_sync_q[2];
			if (flt_sync_q[1] == flt_sync_q[2])
				flt_q <= flt_sync_q[2];
			btn_prev_q <= btn_q;
		end
	end
	assign btn_press = btn_q && !btn_prev_q;
	assign fault     = flt_q;

	// ====================================================================
	// PWM period tick and conversion trigger
	logic [15:0] pwm_cnt_q;
	logic        pwm_tick;
	assign pwm_tick = (pwm_cnt_q == 16'h0000);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pwm_cnt_q        <= '0;
			conversion_start <= 1'b0;
		end
		else
		begin
			pwm_cnt_q        <= pwm_tick ? pwm_period_q - 16'h0001 : pwm_cnt_q - 16'h0001;
			conversion_start <= pwm_tick;
		end
	end

	// ====================================================================
	// run state machine
	logic [15:0] ramp_step_q;
	logic [31:0] ramp_inc_q;
	logic [31:0] ramp_angle_q;
	logic        ramp_done;
	assign ramp_done = (ramp_step_q >= ramp_steps_q);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_q <= ST_STOPPED;
		else if (fault && state_q != ST_STOPPED)
			state_q <= ST_FAULT;
		else
		begin
			unique case (state_q)
				ST_STOPPED: if (btn_press && !fault) state_q <= ST_INIT;
				ST_INIT:    state_q <= ST_RAMP;
				ST_RAMP:    if (btn_press) state_q <= ST_STOPPED;
					else if (ramp_done) state_q <= ST_RUN;
				ST_RUN:     if (btn_press) state_q <= ST_STOPPED;
				ST_FAULT:   state_q <= ST_STOPPED;
			endcase
		end
	end

	// angle increment grows by the acceleration each period
	always_ff @(posedge aclk)
	begin
		if (!aresetn || state_q != ST_RAMP)
		begin
			ramp_step_q  <= '0;
			ramp_inc_q   <= '0;
			ramp_angle_q <= '0;
		end
		else if (conversion_done)
		begin
			ramp_step_q  <= ramp_step_q + 16'h0001;
			ramp_inc_q   <= ramp_inc_q + {16'h0, ramp_accel_q};
			ramp_angle_q <= ramp_angle_q + ramp_inc_q;
		end
	end

	assign windings_enable = (state_q == ST_RAMP) || (state_q == ST_RUN);
	assign regulators_run  = windings_enable;
	assign control_clear   = (state_q == ST_INIT);
	assign speed_pi_enable = (state_q == ST_RUN) && !TORQUE_ONLY_SELECT;

	// ====================================================================
	// per-period computation, started by conversion completion
	calc_state_t        calc_q;
	logic signed [31:0] div_d;
	logic signed [31:0] div_q_q;
	logic signed [31:0] prod_d;
	logic signed [31:0] prod_q;
	q15_t               fw_d;
	logic [15:0]        over;
	logic [15:0]        span;
	logic [3:0]         idx;
	logic [31:0]        frac;
	logic signed [16:0] diff;

	// interpolate: position above rated speed scaled across the table span
	always_comb
	begin
		over = 16'(pot_reference) - rated_speed_rpm;
		span = max_weakened_speed_rpm - rated_speed_rpm;
		idx  = 4'h0;
		frac = '0;
		diff = '0;
		fw_d = '0;
		// a negative reference must never look like a high speed
		if (span != 16'h0 && 17'(pot_reference) > $signed({1'b0, rated_speed_rpm}))
		begin
			frac = 32'((32'(over) * 32'd15 * 32'd4096) / 32'(span));
			if (frac >= 32'd61440)
				fw_d = weak_table_q[15];
			else
			begin
				idx  = frac[15:`TABLE_SHIFT];
				diff = 17'(weak_table_q[idx + 4'h1]) - 17'(weak_table_q[idx]);
				fw_d = 16'(weak_table_q[idx]
					+ ((32'(diff) * 32'($signed({1'b0, frac[11:0]}))) >>> `TABLE_SHIFT));
			end
			if (fw_d > 0)
				fw_d = '0;
		end
	end

	always_comb
	begin
		prod_d = 32'(d_pi_output) * 32'(bus_voltage_target);
		prod_q = 32'(q_pi_output) * 32'(bus_voltage_target);
		div_d  = (bus_voltage_measured > 0) ? prod_d / 32'(bus_voltage_measured) : 32'(d_pi_output);
		div_q_q = (bus_voltage_measured > 0) ? prod_q / 32'(bus_voltage_measured)
			: 32'(q_pi_output);
	end

	function automatic q15_t sat16(input logic signed [31:0] v);
		if (v > 32'sd32767)
			return 16'sh7FFF;
		if (v < -32'sd32768)
			return -16'sh8000;
		return v[15:0];
	endfunction

	always_ff @(posedge aclk)
	begin
		if (!aresetn || state_q == ST_INIT || state_q == ST_STOPPED)
		begin
			velocity_reference         <= '0;
			q_current_reference        <= '0;
			d_current_reference        <= '0;
			speed_error                <= '0;
			commutation_angle          <= '0;
			direct_voltage_command     <= '0;
			quadrature_voltage_command <= '0;
			commands_valid             <= 1'b0;
		end
		else
		begin
			commands_valid <= conversion_done;
			if (conversion_done)
			begin
				velocity_reference <= pot_reference;
				speed_error        <= pot_reference - measured_speed;
				if (state_q == ST_RAMP)
				begin
					q_current_reference <= pot_reference;
					d_current_reference <= '0;
					commutation_angle   <= ramp_angle_q[31:16];
				end
				else
				begin
					q_current_reference <= TORQUE_ONLY_SELECT ? pot_reference
						: speed_pi_output;
					d_current_reference <= fw_d;
					commutation_angle   <= estimator_angle;
				end
				// scaling by target over measured is the same algebra in both cases;
				// equal voltages give the regulator output back exactly
				if (ripple_en_q && bus_voltage_measured != bus_voltage_target)
				begin
					direct_voltage_command     <= sat16(div_d);
					quadrature_voltage_command <= sat16(div_q_q);
				end
				else
				begin
					direct_voltage_command     <= d_pi_output;
					quadrature_voltage_command <= q_pi_output;
				end
			end
		end
	end

	// ====================================================================
	// checks
	a_stop_deenergise: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_STOPPED |-> !windings_enable)
		else $error("windings energised while stopped");
	a_fault_returns: assert property (@(posedge aclk) disable iff (!aresetn)
		(fault && state_q != ST_STOPPED) |=> state_q == ST_FAULT)
		else $error("fault did not stop motor");
	a_fault_exit: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == ST_FAULT && !fault) |=> state_q == ST_STOPPED)
		else $error("fault state not left for stopped");
	a_stop_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == ST_STOPPED && !btn_press) |=> state_q == ST_STOPPED)
		else $error("stopped state left without a press");
	a_init_passes: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == ST_STOPPED && btn_press && !fault)
		|=> control_clear ##1 !control_clear)
		else $error("init state not passed once");
	a_no_weak_rated: assert property (@(posedge aclk) disable iff (!aresetn)
		(conversion_done && state_q == ST_RUN && pot_reference <= $signed(rated_speed_rpm))
		|=> d_current_reference == 0)
		else $error("weakening below rated speed");
	a_weak_negative: assert property (@(posedge aclk) disable iff (!aresetn)
		d_current_reference <= 0)
		else $error("d reference positive");
	a_torque_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
		(TORQUE_ONLY_SELECT && conversion_done && state_q == ST_RUN)
		|=> q_current_reference == $past(pot_reference))
		else $error("torque mode not bypassed");
	a_ramp_torque: assert property (@(posedge aclk) disable iff (!aresetn)
		(conversion_done && state_q == ST_RAMP && !fault)
		|=> q_current_reference == $past(pot_reference))
		else $error("start-up torque not from potentiometer");
	a_ripple_equal: assert property (@(posedge aclk) disable iff (!aresetn)
		(conversion_done && state_q == ST_RUN && bus_voltage_measured == bus_voltage_target)
		|=> direct_voltage_command == $past(d_pi_output)
		&& quadrature_voltage_command == $past(q_pi_output))
		else $error("equal bus changed commands");
	a_ramp_accel: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == ST_RAMP && $past(state_q) == ST_RAMP && $past(conversion_done))
		|-> ramp_inc_q == $past(ramp_inc_q) + {16'h0, $past(ramp_accel_q)})
		else $error("ramp increment not growing");
	a_conv_period: assert property (@(posedge aclk) disable iff (!aresetn)
		pwm_tick |=> conversion_start)
		else $error("conversion not started");
endmodule // foc_supervisory_control

// [foc_supervisory_control_tb_top.sv]
// self-checking bench of the supervisory motor control block
`timescale 1ns/1ps
`include "foc_supervisory_map.svh"
module foc_supervisory_control_tb_top;
	import foc_supervisory_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, start_stop_button, fault_in, conversion_start, conversion_done;
	logic        windings_enable, regulators_run, speed_pi_enable, control_clear, commands_valid;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb, lag;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	q15_t        pot_reference, measured_speed, speed_pi_output, d_pi_output, q_pi_output;
	q15_t        estimator_angle, bus_voltage_measured, speed_error, velocity_reference;
	q15_t        q_current_reference, d_current_reference, commutation_angle;
	q15_t        direct_voltage_command, quadrature_voltage_command, pot, dv, qv, b;
	int          fails, checks_done, cycles, k, h, r;

	// =======================
	// clock, design, partner
	// =======================
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	foc_supervisory_control #(.TORQUE_ONLY_SELECT(1'b0)) DUT (.*);
	inverter_model partner (
		.aclk             (aclk),
		.aresetn          (aresetn),
		.conversion_start (conversion_start),
		.lag              (lag),
		.conversion_done  (conversion_done)
	);

	// =======================
	// tasks
	// =======================
	task automatic wrap_up();
		if (fails == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// handshakes are looked at on the falling edge, where they are settled
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(negedge aclk);
			aw_done = aw_done | s_axi_awready;
			w_done = w_done | s_axi_wready;
			@(posedge aclk);
			if (aw_done)
				s_axi_awvalid <= 1'b0;
			if (w_done)
				s_axi_wvalid <= 1'b0;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		@(posedge aclk);
	endtask
	task automatic axr(input logic [11:0] a);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		@(posedge aclk);
	endtask
	task automatic wait_cv();
		do @(negedge aclk); while (commands_valid !== 1'b1);
		@(posedge aclk);
	endtask
	// new samples land after one computation, results are read after the next
	task automatic comp(input q15_t p, input q15_t dp, input q15_t qp, input q15_t bus);
		wait_cv();
		pot_reference        <= p;
		d_pi_output          <= dp;
		q_pi_output          <= qp;
		bus_voltage_measured <= bus;
		measured_speed       <= q15_t'($urandom_range(0, 4095));
		speed_pi_output      <= q15_t'($urandom);
		estimator_angle      <= q15_t'($urandom);
		lag                  <= 4'($urandom_range(0, 9));
		wait_cv();
	endtask
	task automatic press();
		start_stop_button <= 1'b1;
		repeat (8) @(posedge aclk);
		start_stop_button <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask
	function automatic q15_t rip(input q15_t p, input q15_t m);
		return q15_t'((int'(p) * 16384) / int'(m));
	endfunction

	// =======================
	// timeout
	// =======================
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 80000)
		begin
			fails++;
			$display("ERROR %0t timeout", $time);
			wrap_up();
		end
	end

	// =======================
	// main sequence
	// =======================
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, start_stop_button, fault_in} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{pot_reference, measured_speed, speed_pi_output, d_pi_output} = '0;
		{q_pi_output, estimator_angle} = '0;
		bus_voltage_measured = 16'sh4000;
		{aresetn, fails, checks_done, cycles} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb, lag} = {1'b1, 1'b1, 4'hF, 4'h1};
		void'($urandom(99408));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(`REG_STATUS);
		chk(rd, 32'h0000_0001);
		chk(windings_enable, 1'b0);
		s_axi_wstrb <= 4'h0;
		axw(`REG_RATED, 32'h0000_1234);
		s_axi_wstrb <= 4'hF;
		axr(`REG_RATED);
		chk(rd[15:0], `RATED_RESET);
		axr(12'h0FC);
		chk(rs, `RESP_SLVERR);
		axw(12'h0F0, 32'h0000_0001);
		chk(rs, `RESP_SLVERR);
		axw(`REG_PWM_PERIOD, 32'h0000_0040);
		chk(rs, `RESP_OKAY);
		axw(`REG_RAMP_STEPS, 32'h0000_0003);
		for (k = 0; k < 16; k++)
			axw(12'(`REG_TABLE_BASE + 4 * k), 32'(-k * 256));
		axr(`REG_TABLE_TOP);
		chk(rd[15:0], 16'hF100);
		do @(negedge aclk); while (!conversion_start);
		do @(negedge aclk); while (!conversion_start);
		h = 0;
		do
		begin
			@(negedge aclk);
			h++;
		end while (!conversion_start);
		chk(h, 32'h40);
		@(posedge aclk);
		press();
		axr(`REG_STATUS);
		chk(rd, 32'h0000_0004);
		comp(16'sh0500, 16'sh0100, 16'sh0200, 16'sh2000);
		chk({windings_enable, regulators_run, speed_pi_enable}, 3'b110);
		chk(q_current_reference, 16'sh0500);
		repeat (4) wait_cv();
		axr(`REG_STATUS);
		chk(rd, 32'h0000_0008);
		comp(16'sh1000, 16'sh0100, 16'sh0200, 16'sh2000);
		chk(d_current_reference, 16'sh0000);
		chk(direct_voltage_command, 16'sh0100);
		chk(quadrature_voltage_command, 16'sh0200);
		chk(commutation_angle, estimator_angle);
		axw(`REG_MAXW, 32'h0000_1700);
		// positions in half table steps; above 29 means below rated speed
		for (h = 0; h < 14; h++)
		begin
			k = (h == 0) ? 0 : (h == 1) ? 29 : $urandom_range(0, 40);
			pot = (k > 29) ? q15_t'(16'h0800 - (k - 29) * 32) : q15_t'(16'h0800 + k * 128);
			comp(pot, q15_t'($urandom), q15_t'($urandom), 16'sh3000);
			chk(d_current_reference, (k > 29) ? 16'sh0000 : q15_t'(-k * 128));
			chk(velocity_reference, pot);
			chk(speed_pi_enable, 1'b1);
			chk(q_current_reference, speed_pi_output);
			chk(speed_error, q15_t'(pot - measured_speed));
			chk(direct_voltage_command, d_pi_output);
		end
		axw(`REG_CTRL, 32'h0000_0001);
		for (h = 0; h < 9; h++)
		begin
			b = (h % 3 == 0) ? 16'sh4000 : (h % 3 == 1) ? 16'sh2000 : 16'sh6000;
			r = $urandom_range(0, 10000) - 5000;
			dv = q15_t'(3 * r);
			r = $urandom_range(0, 10000) - 5000;
			qv = q15_t'(3 * r);
			comp(16'sh0400, dv, qv, b);
			chk(direct_voltage_command, rip(dv, b));
			chk(quadrature_voltage_command, rip(qv, b));
		end
		press();
		axr(`REG_STATUS);
		chk(rd, 32'h0000_0001);
		press();
		fault_in <= 1'b1;
		repeat (6) @(posedge aclk);
		fault_in <= 1'b0;
		repeat (200) @(posedge aclk);
		axr(`REG_STATUS);
		chk(rd, 32'h0000_0001);
		chk(windings_enable, 1'b0);
		wrap_up();
	end
endmodule // foc_supervisory_control_tb_top

// [foc_supervisory_map.svh]
// constants and register map of the supervisory motor control block
`ifndef FOC_SUPERVISORY_MAP_SVH
`define FOC_SUPERVISORY_MAP_SVH
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_RATED       12'h008
`define REG_MAXW        12'h00C
`define REG_BUS_TARGET  12'h010
`define REG_RAMP_ACCEL  12'h014
`define REG_RAMP_STEPS  12'h018
`define REG_PWM_PERIOD  12'h01C
`define REG_TABLE_BASE  12'h040
`define REG_TABLE_TOP   12'h07C
`define CTRL_RIPPLE_BIT 0
`define CTRL_RESET      32'h0000_0000
`define RATED_RESET     16'h0800
`define MAXW_RESET      16'h0800
`define TARGET_RESET    16'h4000
`define ACCEL_RESET     16'h0004
`define STEPS_RESET     16'h0400
`define PERIOD_RESET    16'h09C4
`define TABLE_SHIFT     12
`define FRAC_MASK       16'h0FFF
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

// [foc_supervisory_pkg.sv]
// types of the supervisory motor control block
package foc_supervisory_pkg;
	typedef enum logic [4:0] {
		ST_STOPPED = 5'b00001,
		ST_INIT    = 5'b00010,
		ST_RAMP    = 5'b00100,
		ST_RUN     = 5'b01000,
		ST_FAULT   = 5'b10000
	} run_state_t;
	typedef enum logic [2:0] {
		CS_IDLE = 3'b001,
		CS_DIV  = 3'b010,
		CS_OUT  = 3'b100
	} calc_state_t;
	typedef logic signed [15:0] q15_t;
endpackage

// [inverter_model.sv]
// inverter side model: answers each conversion start with a conversion done pulse
`timescale 1ns/1ps
module inverter_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       conversion_start,
	input  wire logic [3:0] lag,
	output      logic       conversion_done
);
	// ================
	// conversion delay
	// ================
	// lag is taken at the start pulse, so the bench may switch between prompt and slow answers
	logic [3:0] cnt_q;
	logic       busy_q;
	always_ff @(posedge aclk)
	begin
		conversion_done <= 1'b0;
		if (!aresetn)
		begin
			busy_q <= 1'b0;
			cnt_q  <= 4'h0;
		end
		else if (conversion_start)
		begin
			busy_q <= 1'b1;
			cnt_q  <= lag;
		end
		else if (busy_q)
		begin
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h0)
			begin
				busy_q          <= 1'b0;
				conversion_done <= 1'b1;
			end
		end
	end
endmodule // inverter_model
